//--- rtl/ckr_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: ULPI immediate register addressing, 6-bit addresses.
// Notes: Included by the carkit register bank only.
`ifndef CKR_DEFINES_SVH
`define CKR_DEFINES_SVH

`define CKR_ADDR_STATUS 6'h20
`define CKR_ADDR_LATCH 6'h21
`define CKR_ADDR_HS_COMP 6'h31
`define CKR_ADDR_VENDOR_LO 6'h30
`define CKR_ADDR_VENDOR_HI 6'h3f

`define CKR_ST_ID_FLOAT 0
`define CKR_ST_CONTACT 1
`define CKR_ST_DP_CARKIT 2
`define CKR_ST_CODE_LSB 3
`define CKR_ST_CONV_DONE 6

`define CKR_LT_ID_FLOAT 0
`define CKR_LT_CONTACT 1
`define CKR_LT_DP_CARKIT 2
`define CKR_LT_CONV 3

`define CKR_HS_SQUELCH_LSB 0
`define CKR_HS_DRIVE_LSB 4
`define CKR_SQUELCH_RESET 2'h0
`define CKR_DRIVE_RESET 3'h0

`define CKR_TXCMD_WRITE 2'h2
`define CKR_TXCMD_READ 2'h3
`define CKR_RXCMD_ALT_INT 7

`define CKR_CLK_PERIOD_NS 20
`define CKR_CONV_TIME_NS 282000
`define CKR_CONV_CYCLES \
  ((`CKR_CONV_TIME_NS + `CKR_CLK_PERIOD_NS - 1) / `CKR_CLK_PERIOD_NS)

`endif

//--- rtl/ckr_pkg.sv
// Purpose: Types shared by the carkit register bank.
// Assumes: Count width covers the default conversion time.
// Notes: Constants live in ckr_defines.svh.
package ckr_pkg;

  typedef enum logic [3:0] {
    CKR_IDLE = 4'h0,
    CKR_WCMD = 4'h1,
    CKR_WDATA = 4'h2,
    CKR_WSTP = 4'h3,
    CKR_RCMD = 4'h4,
    CKR_RTURN = 4'h5,
    CKR_RDATA = 4'h6,
    CKR_XTURN = 4'h7,
    CKR_XDATA = 4'h8
  } ckr_state_e;

  typedef logic [14:0] ckr_count_t;

endpackage : ckr_pkg

//--- rtl/ckr_carkit_regs.sv
// Purpose: Carkit status/latch registers and HS trim register on ULPI.
// Assumes: All inputs except the async i_reset synchronous to the 50 MHz (20 ns period) ULPI clock domain.
// Notes: Converter, enable registers and vendor conversion register sit
//   outside; they connect through plain inputs.
`timescale 1ns/1ps
`include "ckr_defines.svh"

module ckr_carkit_regs #(
  parameter int CONV_CYCLES = `CKR_CONV_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_ulpi_data,
  output logic [7:0] o_ulpi_data,
  output logic o_ulpi_data_oe_n,
  output logic o_ulpi_dir,
  output logic o_ulpi_nxt,
  input wire logic i_ulpi_stp,
  input wire logic [1:0] i_linestate,
  input wire logic [1:0] i_vbus_state,
  input wire logic i_id_level,
  input wire logic i_id_float_raw,
  input wire logic i_contact_cmp,
  input wire logic [2:0] i_id_resistance_code,
  input wire logic i_conv_start,
  input wire logic i_vendor_conv_read,
  input wire logic i_id_line_bias_en,
  input wire logic i_detect_sink_en,
  input wire logic i_id_float_rise_en,
  input wire logic i_id_float_fall_en,
  input wire logic i_contact_detect_irq_en,
  input wire logic i_id_conv_irq_en,
  input wire logic i_vendor_conv_irq_en,
  output logic [1:0] o_squelch_trim,
  output logic [2:0] o_hs_drive_trim,
  output logic o_id_conv_complete,
  output logic o_conv_busy
);
  import ckr_pkg::*;

  initial
  begin
    if (CONV_CYCLES < 1 || CONV_CYCLES > 32767)
    begin
      $error("CONV_CYCLES out of range for the conversion counter");
    end
    if (`CKR_ST_CODE_LSB + 3 > `CKR_ST_CONV_DONE)
    begin
      $error("Status code field overlaps the done bit");
    end
    if (`CKR_HS_DRIVE_LSB + 3 > 8)
    begin
      $error("Drive trim field does not fit the byte");
    end
  end

  localparam ckr_count_t CONV_LAST = ckr_count_t'(CONV_CYCLES - 1);

  typedef struct packed {
    ckr_state_e state;
    logic [5:0] addr;
    logic [7:0] dout;
    logic [1:0] squelch;
    logic [2:0] drive;
    logic id_latch;
    logic contact_latch;
    logic conv_latch;
    logic alt_pending;
    logic float_prev;
    logic contact_prev;
    logic done;
    logic busy;
    ckr_count_t count;
  } ckr_regs_s;

  ckr_regs_s r_q;
  ckr_regs_s r_d;

  logic float_now;
  logic contact_now;
  logic ev_id;
  logic ev_contact;
  logic ev_conv;
  logic conv_finish;
  logic [7:0] status_byte;
  logic [7:0] latch_byte;
  logic [7:0] hs_byte;
  logic [7:0] read_byte;
  logic [7:0] rxcmd_byte;

  always_comb
  begin
    float_now = i_id_float_raw & i_id_line_bias_en;
    contact_now = i_contact_cmp & i_detect_sink_en;
    conv_finish = r_q.busy && (r_q.count == CONV_LAST);
    ev_id = (float_now & ~r_q.float_prev & i_id_float_rise_en) |
            (~float_now & r_q.float_prev & i_id_float_fall_en);
    ev_contact = (contact_now ^ r_q.contact_prev) & i_contact_detect_irq_en;
    ev_conv = conv_finish & ~r_q.done &
              (i_id_conv_irq_en | i_vendor_conv_irq_en);

    status_byte = 8'h00;
    status_byte[`CKR_ST_ID_FLOAT] = float_now;
    status_byte[`CKR_ST_CONTACT] = contact_now;
    // Carkit DP detection is not built; its bits stay zero
    status_byte[`CKR_ST_DP_CARKIT] = 1'b0;
    status_byte[`CKR_ST_CODE_LSB +: 3] = i_id_resistance_code;
    status_byte[`CKR_ST_CONV_DONE] = r_q.done;

    latch_byte = 8'h00;
    latch_byte[`CKR_LT_ID_FLOAT] = r_q.id_latch;
    latch_byte[`CKR_LT_CONTACT] = r_q.contact_latch;
    latch_byte[`CKR_LT_DP_CARKIT] = 1'b0;
    latch_byte[`CKR_LT_CONV] = r_q.conv_latch;

    hs_byte = 8'h00;
    hs_byte[`CKR_HS_SQUELCH_LSB +: 2] = r_q.squelch;
    hs_byte[`CKR_HS_DRIVE_LSB +: 3] = r_q.drive;

    unique case (r_q.addr)
      `CKR_ADDR_STATUS:
      begin
        read_byte = status_byte;
      end
      `CKR_ADDR_LATCH:
      begin
        read_byte = latch_byte;
      end
      `CKR_ADDR_HS_COMP:
      begin
        read_byte = hs_byte;
      end
      default:
      begin
        read_byte = 8'h00;
      end
    endcase

    // RXCMD layout: linestate, vbus state, idle event bits, ID level
    rxcmd_byte = 8'h00;
    rxcmd_byte[1:0] = i_linestate;
    rxcmd_byte[3:2] = i_vbus_state;
    rxcmd_byte[6] = i_id_level;
    rxcmd_byte[`CKR_RXCMD_ALT_INT] = 1'b1;
  end

  always_comb
  begin
    r_d = r_q;
    r_d.float_prev = float_now;
    r_d.contact_prev = contact_now;

    // conversion timer
    // A start while busy is ignored; the running count is kept
    if (r_q.busy)
    begin
      if (conv_finish)
      begin
        r_d.busy = 1'b0;
        r_d.count = '0;
      end
      else
      begin
        r_d.count = r_q.count + ckr_count_t'(1);
      end
    end
    else if (i_conv_start)
    begin
      r_d.busy = 1'b1;
      r_d.count = '0;
    end

    // only vendor read clears done
    // A finish in the same cycle wins over the clear
    if (i_vendor_conv_read)
    begin
      r_d.done = 1'b0;
    end
    if (conv_finish)
    begin
      r_d.done = 1'b1;
    end

    unique case (r_q.state)
      CKR_IDLE:
      begin
        // Link commands take priority; RXCMD waits for a quiet bus
        // A zero byte means the link is idle, so dir may be taken
        if (i_ulpi_data[7:6] == `CKR_TXCMD_WRITE)
        begin
          r_d.addr = i_ulpi_data[5:0];
          r_d.state = CKR_WCMD;
        end
        else if (i_ulpi_data[7:6] == `CKR_TXCMD_READ)
        begin
          r_d.addr = i_ulpi_data[5:0];
          r_d.state = CKR_RCMD;
        end
        else if (r_q.alt_pending && i_ulpi_data == 8'h00)
        begin
          r_d.state = CKR_XTURN;
        end
      end
      CKR_WCMD:
      begin
        r_d.state = CKR_WDATA;
      end
      CKR_WDATA:
      begin
        if (r_q.addr == `CKR_ADDR_HS_COMP)
        begin
          r_d.squelch = i_ulpi_data[`CKR_HS_SQUELCH_LSB +: 2];
          r_d.drive = i_ulpi_data[`CKR_HS_DRIVE_LSB +: 3];
        end
        r_d.state = CKR_WSTP;
      end
      CKR_WSTP:
      begin
        if (i_ulpi_stp)
        begin
          r_d.state = CKR_IDLE;
        end
      end
      CKR_RCMD:
      begin
        r_d.state = CKR_RTURN;
      end
      CKR_RTURN:
      begin
        // immediate read data
        // Data is captured before the clear, so no set bit is lost
        r_d.dout = read_byte;
        r_d.state = CKR_RDATA;
        if (r_q.addr == `CKR_ADDR_LATCH)
        begin
          r_d.id_latch = 1'b0;
          r_d.contact_latch = 1'b0;
          r_d.conv_latch = 1'b0;
        end
      end
      CKR_RDATA:
      begin
        r_d.state = CKR_IDLE;
      end
      CKR_XTURN:
      begin
        r_d.dout = rxcmd_byte;
        r_d.alt_pending = 1'b0;
        r_d.state = CKR_XDATA;
      end
      CKR_XDATA:
      begin
        r_d.state = CKR_IDLE;
      end
      default:
      begin
        r_d.state = CKR_IDLE;
      end
    endcase

    if (ev_id)
    begin
      r_d.id_latch = 1'b1;
    end
    if (ev_contact)
    begin
      r_d.contact_latch = 1'b1;
    end
    if (ev_conv)
    begin
      r_d.conv_latch = 1'b1;
    end
    if (ev_id | ev_contact | ev_conv)
    begin
      r_d.alt_pending = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      r_q <= '{
        state: CKR_IDLE,
        squelch: `CKR_SQUELCH_RESET,
        drive: `CKR_DRIVE_RESET,
        count: '0,
        default: '0
      };
    end
    else
    begin
      r_q <= r_d;
    end
  end

  always_comb
  begin
    o_ulpi_nxt = (r_q.state == CKR_WCMD) || (r_q.state == CKR_WDATA) ||
                 (r_q.state == CKR_RCMD);
    o_ulpi_dir = (r_q.state == CKR_RTURN) || (r_q.state == CKR_RDATA) ||
                 (r_q.state == CKR_XTURN) || (r_q.state == CKR_XDATA);
    // Bus is driven only after the turnaround cycle
    o_ulpi_data_oe_n = !((r_q.state == CKR_RDATA) ||
                         (r_q.state == CKR_XDATA));
  end

  assign o_ulpi_data = r_q.dout;
  assign o_squelch_trim = r_q.squelch;
  assign o_hs_drive_trim = r_q.drive;
  assign o_id_conv_complete = r_q.done;
  assign o_conv_busy = r_q.busy;

endmodule : ckr_carkit_regs

//--- dv/ckr_carkit_regs_sva.sv
// Purpose: Port checks of the carkit bank.
// Assumes: Async active-high reset.
// Notes: Bound below.
`timescale 1ns/1ps
module ckr_carkit_regs_sva #(
  parameter int CONV_CYCLES = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_ulpi_data,
  input wire logic [7:0] o_ulpi_data,
  input wire logic o_ulpi_data_oe_n,
  input wire logic o_ulpi_dir,
  input wire logic o_ulpi_nxt,
  input wire logic i_conv_start,
  input wire logic i_vendor_conv_read,
  input wire logic [1:0] o_squelch_trim,
  input wire logic [2:0] o_hs_drive_trim,
  input wire logic o_id_conv_complete,
  input wire logic o_conv_busy
);
  logic [15:0] cnt_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Busy length, so the done flag can be timed
  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
      cnt_q <= 16'h0;
    else
      cnt_q <= o_conv_busy ? cnt_q + 16'h1 : 16'h0;
  turn_data_a: assert property (
    $rose(o_ulpi_dir) |=> !o_ulpi_data_oe_n ##1 !o_ulpi_dir)
    else $error("bad turnaround");
  drive_dir_a: assert property (
    !o_ulpi_data_oe_n |-> o_ulpi_dir && $past(o_ulpi_dir))
    else $error("drive without dir");
  trim_write_a: assert property (
    $changed({o_hs_drive_trim, o_squelch_trim}) |-> $past(o_ulpi_nxt))
    else $error("trim moved");
  comp_read_a: assert property (
    !o_ulpi_data_oe_n && $past(i_ulpi_data, 3) == 8'hf1 |->
      o_ulpi_data == {1'b0, o_hs_drive_trim, 2'b00, o_squelch_trim})
    else $error("bad trim read");
  latch_zero_a: assert property (
    !o_ulpi_data_oe_n && $past(i_ulpi_data, 3) == 8'he1 |->
      o_ulpi_data[7:4] == 4'h0 && !o_ulpi_data[2])
    else $error("latch spare bit set");
  conv_start_a: assert property (
    $rose(o_conv_busy) |-> $past(i_conv_start))
    else $error("busy without start");
  conv_time_a: assert property (
    $rose(o_id_conv_complete) |-> cnt_q == 16'(CONV_CYCLES))
    else $error("bad conversion time");
  done_clear_a: assert property (
    $fell(o_id_conv_complete) |-> $past(i_vendor_conv_read))
    else $error("done cleared");
endmodule : ckr_carkit_regs_sva

bind ckr_carkit_regs ckr_carkit_regs_sva #(.CONV_CYCLES(CONV_CYCLES)) chk (
  .i_clk, .i_reset, .i_ulpi_data, .o_ulpi_data, .o_ulpi_data_oe_n,
  .o_ulpi_dir, .o_ulpi_nxt, .i_conv_start, .i_vendor_conv_read,
  .o_squelch_trim, .o_hs_drive_trim, .o_id_conv_complete, .o_conv_busy
);

//--- dv/ckr_link_model.sv
// Purpose: ULPI link model.
// Assumes: Commands wait while dir is high.
// Notes: Released bus shows the inverted byte.
`timescale 1ns/1ps
module ckr_link_model (
  input wire logic i_clk,
  input wire logic i_dir,
  input wire logic i_nxt,
  input wire logic i_oe_n,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_stp
);
  logic [7:0] rx;
  initial {o_data, o_stp, rx} = 17'h0;
  // Read data has bit 7 clear, so this keeps only RXCMD bytes
  always @(negedge i_clk)
    if (!i_oe_n && i_data[7])
      rx = i_data;
  task go(input logic [7:0] b);
    while (i_dir) @(posedge i_clk) #1;
    o_data = b;
    do @(negedge i_clk); while (!i_nxt);
    @(posedge i_clk) #1;
  endtask : go
  task wr(input logic [5:0] a, input logic [7:0] b);
    go({2'b10, a});
    go(b);
    {o_data, o_stp} = 9'h1;
    @(posedge i_clk) #1 o_stp = 1'b0;
  endtask : wr
  task rd(input logic [5:0] a, output logic [7:0] b);
    go({2'b11, a});
    o_data = ~o_data;
    do @(negedge i_clk); while (i_oe_n);
    b = i_data;
    @(posedge i_clk) #1 o_data = 8'h00;
    @(posedge i_clk) #1;
  endtask : rd
endmodule : ckr_link_model

//--- dv/ckr_carkit_regs_bench.sv
// Purpose: Self-checking bench of the carkit bank.
// Assumes: Short conversion count.
// Notes: Random data from a fixed-seed LFSR.
`timescale 1ns/1ps
module ckr_carkit_regs_bench;
  localparam int CC = 8;
  logic clk, rst, stp, oe_n, dir, nxt, st, vr, done, busy;
  logic [7:0] ld, pd, det, en, v;
  logic [3:0] ls;
  logic [1:0] sq;
  logic [2:0] dr;
  logic [31:0] lf;
  int miscompares, compares;
  ckr_carkit_regs #(.CONV_CYCLES(CC)) DUT (
    .i_clk(clk), .i_reset(rst), .i_ulpi_data(ld), .o_ulpi_data(pd),
    .o_ulpi_data_oe_n(oe_n), .o_ulpi_dir(dir), .o_ulpi_nxt(nxt),
    .i_ulpi_stp(stp), .i_linestate(ls[1:0]), .i_vbus_state(ls[3:2]),
    .i_id_level(det[5]), .i_id_float_raw(det[0]), .i_contact_cmp(det[1]),
    .i_id_resistance_code(det[4:2]), .i_conv_start(st),
    .i_vendor_conv_read(vr), .i_id_line_bias_en(det[6]),
    .i_detect_sink_en(det[7]), .i_id_float_rise_en(en[0]),
    .i_id_float_fall_en(en[1]), .i_contact_detect_irq_en(en[2]),
    .i_id_conv_irq_en(en[3]), .i_vendor_conv_irq_en(en[4]),
    .o_squelch_trim(sq), .o_hs_drive_trim(dr),
    .o_id_conv_complete(done), .o_conv_busy(busy));
  ckr_link_model m (.i_clk(clk), .i_dir(dir), .i_nxt(nxt), .i_oe_n(oe_n),
    .i_data(pd), .o_data(ld), .o_stp(stp));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  // Flags read as detector AND its sensing enable
  function automatic logic [7:0] stat(input logic [7:0] d, input logic c);
    return {1'b0, c, d[4:2], 1'b0, d[1] & d[7], d[0] & d[6]};
  endfunction : stat
  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task rc(input logic [5:0] a, input logic [7:0] e);
    m.rd(a, v);
    chk(v, e);
  endtask : rc
  task results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  initial forever #10 clk = ~clk;
  // The tests need well under a thousand cycles
  initial
  begin
    #100000 miscompares++;
    results;
  end
  initial
  begin
    {clk, rst, st, vr, det, en, ls} = 24'h400000;
    lf = 32'h0a5741a4;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    rc(6'h31, 8'h00);
    repeat (4)
    begin
      lf = nx(lf);
      m.wr(6'h31, lf[7:0]);
      rc(6'h31, lf[7:0] & 8'h73);
      chk({1'b0, dr, 2'b00, sq}, lf[7:0] & 8'h73);
    end
    m.wr(6'h20, 8'hff);
    m.wr(6'h21, 8'hff);
    rc(6'h31, lf[7:0] & 8'h73);
    rc(6'h3f, 8'h00);
    $display("trim test done");
    for (int i = 0; i < 8; i++)
    begin
      lf = nx(lf);
      {det, ls} = {lf[7:5], i[2:0], lf[1:0], lf[11:8]};
      rc(6'h20, stat(det, 1'b0));
    end
    $display("status test done");
    det = 8'hc0;
    @(posedge clk) #1 en = 8'h07;
    det = 8'hc3;
    repeat (5) @(posedge clk) #1;
    chk(m.rx, {1'b1, det[5], 2'b00, ls});
    rc(6'h21, 8'h03);
    rc(6'h21, 8'h00);
    {en, det} = 16'h06c0;
    rc(6'h21, 8'h03);
    {en, det} = 16'h02c3;
    rc(6'h21, 8'h00);
    $display("latch test done");
    {en, st} = 9'h21;
    @(posedge clk) #1 st = 1'b0;
    chk({6'h0, busy, done}, 8'h02);
    repeat (CC + 4) @(posedge clk) #1;
    chk({6'h0, busy, done}, 8'h01);
    rc(6'h20, stat(det, 1'b1));
    rc(6'h21, 8'h08);
    rc(6'h20, stat(det, 1'b1));
    vr = 1'b1;
    @(posedge clk) #1 vr = 1'b0;
    rc(6'h20, stat(det, 1'b0));
    $display("conversion test done");
    results;
  end
endmodule : ckr_carkit_regs_bench
